// ---- rtl/fpsc_top.sv ----
// Flash protection flags, ready/busy tracking and the security lock.
// Assumes a flash command decoder and flash macro on aclk, and a
// power-on reset that is synchronous and active low like aresetn.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - Status register bits 21-16 show one read-only protection flag per block.
// - Data programming into a protected block is refused.
// - Ready flag in bit 0 reads zero while an automatic operation runs.
// - Successful completion sets ready again and new commands are accepted.
// - Failed operation keeps ready at zero until a hardware reset.
// - After reset recovering a lockout, reading becomes available after about 2 ms.
// - With four blocks, flag bits 21:20 read zero.
// - Security register bit 0 is read/write enable, reset only by power-on.
// - Power-on reset forces the security enable to one.
// - Key 0xa74a9d23 then new value within 16 clocks changes the enable.
// - Both keyed writes must be full 32-bit transfers.
// - Protection writing and erasing allowed in chip, boot and writer modes.
// - Protection programming sets exactly one block per operation.
// - Protection erase clears blocks 0-3 or blocks 4-5 together.
// - Protection erase under full lock erases every protection flag.
// - Lock holds only when enable and all protection flags are one.
// - Lock blocks debug port communication and trace output.
// - Lock rejects every command write to the flash except protection erase.
module fpsc_top
    import fpsc_pkg::*;
#(
    parameter int          NUM_BLOCKS    = FPSC_MAX_BLOCKS,
    parameter int          READ_DLY_CYC  = FPSC_READ_DLY_CYC,
    parameter logic [5:0]  PROT_POR_INIT = 6'h00
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        por_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  boot_mode,
    input  wire logic        cmd_valid,
    input  wire logic [1:0]  cmd_kind,
    input  wire logic [2:0]  cmd_block,
    output logic             cmd_accept,
    output logic             cmd_reject,
    input  wire logic        auto_done,
    input  wire logic        auto_fail,
    output logic             read_ready,
    output logic             debug_block,
    output logic             trace_block,
    output logic [5:0]       block_protect_flags
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_BLOCKS != 4 && NUM_BLOCKS != FPSC_MAX_BLOCKS)
    begin : g_bad_blocks
        $error("NUM_BLOCKS must be 4 or 6");
    end
    if (READ_DLY_CYC < 1 || READ_DLY_CYC > 65535)
    begin : g_bad_dly
        $error("READ_DLY_CYC out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam logic [5:0]  FLAG_MASK = 6'((1 << NUM_BLOCKS) - 1);
    localparam logic [5:0]  GRP0_MASK = 6'((1 << (FPSC_GRP0_LAST + 1)) - 1);
    localparam logic [15:0] DLY_LOAD  = 16'(READ_DLY_CYC);

    typedef struct packed
    {
        logic        sec;
        logic [5:0]  prot;
        logic        lockout;
        fpsc_state_t fsm;
        fpsc_cmd_t   op_kind;
        logic [2:0]  op_blk;
        logic        op_all;
        logic [15:0] rd_dly;
        logic        acc;
        logic        rej;
        logic [1:0]  mode_s1;
        logic [1:0]  mode_s2;
        logic        aw_got;
        logic [7:0]  awaddr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } fpsc_st_t;

    fpsc_st_t st_ff;
    fpsc_st_t nxt_st;

    fpsc_key_if kif ();

    fpsc_key_seq u_key_seq
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .kif     (kif.seq)
    );

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == FPSC_OFS_SEC) || (a == FPSC_OFS_STAT);
    endfunction

    // ------------------------------------------------------------
    // Derived status
    // ------------------------------------------------------------
    logic [5:0]  flags_vis;
    logic        all_prot;
    logic        locked;
    logic        ready;
    logic        mode_ok;
    logic        do_write;
    logic [31:0] stat_word;
    logic [31:0] sec_word;

    always_comb
    begin
        flags_vis = st_ff.prot & FLAG_MASK;
        all_prot  = (flags_vis == FLAG_MASK);
        locked    = st_ff.sec && all_prot;
        ready     = (st_ff.fsm == FPSC_ST_IDLE);
        mode_ok   = (fpsc_mode_t'(st_ff.mode_s2) != FPSC_MODE_OTHER);
        do_write  = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        stat_word = '0;
        stat_word[FPSC_RDY_BIT] = ready;
        stat_word[FPSC_PROT_LSB +: FPSC_MAX_BLOCKS] = flags_vis;
        sec_word  = '0;
        sec_word[FPSC_SEC_BIT] = st_ff.sec;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.acc     = 1'b0;
        nxt_st.rej     = 1'b0;
        nxt_st.mode_s1 = boot_mode;
        nxt_st.mode_s2 = st_ff.mode_s1;
        if (st_ff.rd_dly != 16'h0000)
        begin
            nxt_st.rd_dly = st_ff.rd_dly - 16'h0001;
        end

        // Flash command gate
        case (st_ff.fsm)
            FPSC_ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    if (locked && fpsc_cmd_t'(cmd_kind) != FPSC_CMD_PROT_ERASE)
                    begin
                        nxt_st.rej = 1'b1;
                    end
                    else if (fpsc_cmd_t'(cmd_kind) == FPSC_CMD_DATA_PROG && cmd_block < 3'(NUM_BLOCKS)
                             && flags_vis[cmd_block])
                    begin
                        nxt_st.rej = 1'b1;
                    end
                    else if ((fpsc_cmd_t'(cmd_kind) == FPSC_CMD_PROT_PROG
                              || fpsc_cmd_t'(cmd_kind) == FPSC_CMD_PROT_ERASE)
                             && (!mode_ok || cmd_block >= 3'(NUM_BLOCKS)))
                    begin
                        nxt_st.rej = 1'b1;
                    end
                    else
                    begin
                        nxt_st.acc     = 1'b1;
                        nxt_st.fsm     = FPSC_ST_BUSY;
                        nxt_st.op_kind = fpsc_cmd_t'(cmd_kind);
                        nxt_st.op_blk  = cmd_block;
                        nxt_st.op_all  = locked;
                    end
                end
            end
            FPSC_ST_BUSY:
            begin
                if (cmd_valid)
                begin
                    nxt_st.rej     = 1'b1;
                    nxt_st.fsm     = FPSC_ST_LOCKED;
                    nxt_st.lockout = 1'b1;
                end
                else if (auto_fail)
                begin
                    nxt_st.fsm = FPSC_ST_FAILED;
                end
                else if (auto_done)
                begin
                    nxt_st.fsm = FPSC_ST_IDLE;
                    if (st_ff.op_kind == FPSC_CMD_PROT_PROG)
                    begin
                        nxt_st.prot[st_ff.op_blk] = 1'b1;
                    end
                    else if (st_ff.op_kind == FPSC_CMD_PROT_ERASE && st_ff.op_all)
                    begin
                        nxt_st.prot = '0;
                    end
                    else if (st_ff.op_kind == FPSC_CMD_PROT_ERASE && st_ff.op_blk <= 3'(FPSC_GRP0_LAST))
                    begin
                        nxt_st.prot = st_ff.prot & ~GRP0_MASK;
                    end
                    else if (st_ff.op_kind == FPSC_CMD_PROT_ERASE)
                    begin
                        nxt_st.prot = st_ff.prot & GRP0_MASK;
                    end
                end
            end
            FPSC_ST_FAILED,
            FPSC_ST_LOCKED:
            begin
                nxt_st.rej = cmd_valid;
            end
            default:
            begin
                nxt_st.fsm = FPSC_ST_IDLE;
            end
        endcase

        // Security enable update from the key sequencer
        if (kif.upd_pulse)
        begin
            nxt_st.sec = kif.upd_value;
        end

        // Write channels, taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (do_write)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = mapped(st_ff.awaddr) ? FPSC_RESP_OKAY : FPSC_RESP_SLVERR;
        end
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end

        // Read channel
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = mapped(s_axi_araddr) ? FPSC_RESP_OKAY : FPSC_RESP_SLVERR;
            if (s_axi_araddr == FPSC_OFS_STAT)
            begin
                nxt_st.rdata = stat_word;
            end
            else if (s_axi_araddr == FPSC_OFS_SEC)
            begin
                nxt_st.rdata = sec_word;
            end
            else
            begin
                nxt_st.rdata = '0;
            end
        end
        else if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
    end

    // Key sequencer sees every completed security register write
    assign kif.wr_pulse = do_write && st_ff.awaddr == FPSC_OFS_SEC;
    assign kif.wr_data  = st_ff.wdata;
    assign kif.wr_full  = (st_ff.wstrb == FPSC_FULL_STRB);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Security and protection survive system reset by design; lockout clears and loads the read delay
    always_ff @(posedge aclk)
    begin
        if (!por_n)
        begin
            st_ff      <= '0;
            st_ff.sec  <= FPSC_SEC_RESET;
            st_ff.prot <= PROT_POR_INIT;
        end
        else if (!aresetn)
        begin
            st_ff         <= '0;
            st_ff.sec     <= st_ff.sec;
            st_ff.prot    <= st_ff.prot;
            st_ff.lockout <= 1'b0;
            st_ff.rd_dly  <= st_ff.lockout ? DLY_LOAD : st_ff.rd_dly;
            st_ff.mode_s1 <= st_ff.mode_s1;
            st_ff.mode_s2 <= st_ff.mode_s2;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready       = !st_ff.aw_got && !st_ff.bvalid;
    assign s_axi_wready        = !st_ff.w_got && !st_ff.bvalid;
    assign s_axi_bvalid        = st_ff.bvalid;
    assign s_axi_bresp         = st_ff.bresp;
    assign s_axi_arready       = !st_ff.rvalid;
    assign s_axi_rvalid        = st_ff.rvalid;
    assign s_axi_rdata         = st_ff.rdata;
    assign s_axi_rresp         = st_ff.rresp;
    assign cmd_accept          = st_ff.acc;
    assign cmd_reject          = st_ff.rej;
    assign read_ready          = (st_ff.rd_dly == 16'h0000);
    assign debug_block         = locked;
    assign trace_block         = locked;
    assign block_protect_flags = flags_vis;

endmodule

// ---- rtl/fpsc_pkg.sv ----
// Constants and types for the flash protection and security controller.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register port.
package fpsc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          FPSC_ADDR_W       = 8;
    localparam logic [7:0]  FPSC_OFS_SEC      = 8'h00;
    localparam logic [7:0]  FPSC_OFS_STAT     = 8'h20;
    localparam int          FPSC_RDY_BIT      = 0;
    localparam int          FPSC_PROT_LSB     = 16;
    localparam int          FPSC_SEC_BIT      = 0;
    localparam logic        FPSC_SEC_RESET    = 1'b1;
    localparam logic [31:0] FPSC_KEY          = 32'ha74a9d23;
    localparam logic [3:0]  FPSC_FULL_STRB    = 4'hf;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int FPSC_KEY_WIN_CLK  = 16;
    localparam int FPSC_CLK_KHZ      = 20_000;
    localparam int FPSC_READ_DLY_US  = 2_000;
    localparam int FPSC_READ_DLY_CYC = FPSC_READ_DLY_US * FPSC_CLK_KHZ / 1000;

    // ------------------------------------------------------------
    // Protection layout
    // ------------------------------------------------------------
    localparam int FPSC_MAX_BLOCKS = 6;
    localparam int FPSC_GRP0_LAST  = 3;

    localparam logic [1:0] FPSC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] FPSC_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0]
    {
        FPSC_CMD_DATA_PROG  = 2'b00,
        FPSC_CMD_PROT_PROG  = 2'b01,
        FPSC_CMD_PROT_ERASE = 2'b10,
        FPSC_CMD_OTHER      = 2'b11
    } fpsc_cmd_t;

    typedef enum logic [1:0]
    {
        FPSC_MODE_SINGLE_CHIP = 2'b00,
        FPSC_MODE_SINGLE_BOOT = 2'b01,
        FPSC_MODE_WRITER      = 2'b10,
        FPSC_MODE_OTHER       = 2'b11
    } fpsc_mode_t;

    typedef enum logic [1:0]
    {
        FPSC_ST_IDLE   = 2'b00,
        FPSC_ST_BUSY   = 2'b01,
        FPSC_ST_FAILED = 2'b11,
        FPSC_ST_LOCKED = 2'b10
    } fpsc_state_t;

endpackage

// ---- rtl/fpsc_key_if.sv ----
// Carries a security register write and its keyed result.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface fpsc_key_if;
    logic        wr_pulse;
    logic [31:0] wr_data;
    logic        wr_full;
    logic        upd_pulse;
    logic        upd_value;

    modport bus (output wr_pulse, output wr_data, output wr_full, input upd_pulse, input upd_value);
    modport seq (input wr_pulse, input wr_data, input wr_full, output upd_pulse, output upd_value);
endinterface

// ---- rtl/fpsc_key_seq.sv ----
// Key-and-window sequencer for the security enable rewrite.
// Assumes one write pulse per completed security register write, on aclk.
`timescale 1ns/1ps
module fpsc_key_seq
    import fpsc_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    fpsc_key_if.seq   kif
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic       armed;
        logic [4:0] age;
        logic       upd;
        logic       val;
    } fpsc_key_st_t;

    localparam logic [4:0] WIN_LAST = 5'(FPSC_KEY_WIN_CLK);

    fpsc_key_st_t st_ff;
    fpsc_key_st_t nxt_st;

    always_comb
    begin
        nxt_st     = st_ff;
        nxt_st.upd = 1'b0;
        if (st_ff.armed && st_ff.age >= WIN_LAST)
        begin
            nxt_st.armed = 1'b0;
        end
        else if (st_ff.armed)
        begin
            nxt_st.age = st_ff.age + 5'h01;
        end
        if (kif.wr_pulse)
        begin
            if (kif.wr_full && kif.wr_data == FPSC_KEY)
            begin
                nxt_st.armed = 1'b1;
                nxt_st.age   = 5'h01;
            end
            else if (st_ff.armed && st_ff.age <= WIN_LAST && kif.wr_full)
            begin
                nxt_st.armed = 1'b0;
                nxt_st.upd   = 1'b1;
                nxt_st.val   = kif.wr_data[FPSC_SEC_BIT];
            end
            else
            begin
                nxt_st.armed = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign kif.upd_pulse = st_ff.upd;
    assign kif.upd_value = st_ff.val;

endmodule

// ---- verification/fpsc_properties.sv ----
// Concurrent checks on the ports of the flash protection controller.
// Assumes one clock domain, por_n and aresetn both synchronous.
`timescale 1ns/1ps
module fpsc_checker
    import fpsc_pkg::*;
#(
    parameter int NUM_BLOCKS = FPSC_MAX_BLOCKS
)
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        por_n,
    input wire logic [1:0]  boot_mode,
    input wire logic        cmd_valid,
    input wire logic [1:0]  cmd_kind,
    input wire logic [2:0]  cmd_block,
    input wire logic        cmd_accept,
    input wire logic        cmd_reject,
    input wire logic        auto_done,
    input wire logic        debug_block,
    input wire logic        trace_block,
    input wire logic [5:0]  block_protect_flags,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !por_n);

    a_cmd_one_answer: assert property (cmd_valid |=> cmd_accept != cmd_reject)
        else $error("command answer not exactly one pulse");
    a_lock_refuses: assert property (debug_block && cmd_valid && cmd_kind != 2'h2 |=> cmd_reject)
        else $error("command taken under lock");
    a_protected_refuse: assert property (cmd_valid && cmd_kind == 2'h0 && cmd_block < NUM_BLOCKS
        && block_protect_flags[cmd_block] |=> cmd_reject) else $error("program of protected block");
    // Two sync flops, so three stable samples ending in the command cycle
    a_mode_refuse: assert property ((boot_mode == 2'h3) [*3] ##0
        (cmd_valid && cmd_kind inside {2'h1, 2'h2}) |=> cmd_reject) else $error("protect op in bad mode");
    a_flag_cause: assert property (!$stable(block_protect_flags) |-> $past(auto_done))
        else $error("flags changed without completion");
    a_prog_one_block: assert property ($countones(block_protect_flags & ~$past(block_protect_flags)) <= 1)
        else $error("more than one flag set at once");
    a_lock_flags: assert property (debug_block |-> trace_block && &block_protect_flags[NUM_BLOCKS-1:0])
        else $error("lock without all flags");
    a_unused_flags: assert property ((block_protect_flags >> NUM_BLOCKS) == 6'h00)
        else $error("absent block flag set");
    a_rdata_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hffc0fffe) == 32'h0)
        else $error("unlisted read bit set");

    c_accept: cover property (cmd_accept);
    c_lock: cover property (debug_block);
    c_lock_reject: cover property (debug_block && cmd_reject);
endmodule

bind fpsc_top fpsc_checker #(.NUM_BLOCKS(NUM_BLOCKS)) i_fpsc_checker (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .boot_mode(boot_mode), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_block(cmd_block), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
    .auto_done(auto_done), .debug_block(debug_block), .trace_block(trace_block),
    .block_protect_flags(block_protect_flags), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// ---- verification/tb_top.sv ----
// Self-checking bench for the flash protection controller.
// Assumes fpsc_pkg, a 50 ns aclk and a shortened read delay.
`timescale 1ns/1ps
module tb_top;
    import fpsc_pkg::*;
    localparam int         RD  = 20;
    localparam logic [7:0] SEC = FPSC_OFS_SEC;
    localparam logic [7:0] STA = FPSC_OFS_STAT;
    localparam logic [3:0] FS  = FPSC_FULL_STRB;
    logic        aclk, aresetn, por_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_accept, cmd_reject;
    logic        auto_done, auto_fail, read_ready, debug_block, trace_block;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, boot_mode, cmd_kind;
    logic [2:0]  cmd_block;
    logic [5:0]  flags, f;
    logic [33:0] rq[$], bq[$], cq[$];
    int          errors, comparisons;

    fpsc_top #(.READ_DLY_CYC(RD)) i_fpsc_top (
        .aclk(aclk), .aresetn(aresetn), .por_n(por_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .boot_mode(boot_mode), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_block(cmd_block),
        .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .auto_done(auto_done), .auto_fail(auto_fail),
        .read_ready(read_ready), .debug_block(debug_block), .trace_block(trace_block),
        .block_protect_flags(flags));

    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Drivers and checking
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [1:0] resp(input logic [7:0] a);
        return (a == SEC || a == STA) ? FPSC_RESP_OKAY : FPSC_RESP_SLVERR;
    endfunction

    function automatic logic [31:0] st(input logic r, input logic [5:0] fl);
        return {10'h0, fl, 15'h0, r};
    endfunction

    // Leading edge wait keeps one assignment per signal per time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        bq.push_back({32'h0, resp(a)});
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'h7;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok || (awvalid && awready);
            w_ok = w_ok || (wvalid && wready);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back({resp(a), exp});
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic key(input logic [3:0] ks, input logic v, input int gap);
        wr(SEC, FPSC_KEY, ks);
        repeat (gap) @(posedge aclk);
        wr(SEC, {31'h0, v}, FS);
    endtask

    task automatic cmd(input logic [1:0] k, input logic [2:0] b, input logic acc);
        cq.push_back({33'h0, acc});
        @(posedge aclk);
        {cmd_valid, cmd_kind, cmd_block} <= {1'b1, k, b};
        @(posedge aclk);
        cmd_valid <= 1'b0;
    endtask

    task automatic op_end(input logic fail);
        @(posedge aclk);
        {auto_done, auto_fail} <= {!fail, fail};
        @(posedge aclk);
        {auto_done, auto_fail} <= 2'h0;
    endtask

    task automatic areset();
        @(posedge aclk);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        if (rvalid && rready)
            check("rdata", {rresp, rdata}, rq.pop_front());
        if (bvalid && bready)
            check("bresp", {32'h0, bresp}, bq.pop_front());
        if (cmd_accept || cmd_reject)
            check("cmd", {33'h0, cmd_accept}, cq.pop_front());
    end

    initial
    begin
        repeat (5000) @(posedge aclk);
        errors++;
        conclude();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        {errors, comparisons} = 64'h0;
        {aresetn, por_n, awvalid, wvalid, bready, arvalid, rready, cmd_valid, auto_done, auto_fail} = 10'h0;
        {awaddr, araddr, wdata, wstrb, boot_mode, cmd_kind, cmd_block} = 59'h0;
        repeat (5) @(posedge aclk);
        {por_n, aresetn} <= 2'h3;
        void'($urandom(72939));
        rd(STA, st(1'b1, 6'h00));
        rd(SEC, 32'h1);
        rd(8'h04, 32'h0);
        wr(8'h04, $urandom, FS);
        wr(STA, $urandom, FS);
        wr(SEC, 32'h0, FS);
        rd(STA, st(1'b1, 6'h00));
        rd(SEC, 32'h1);
        key(FS, 1'b0, 0);
        rd(SEC, 32'h0);
        key(4'h7, 1'b1, 0);
        rd(SEC, 32'h0);
        key(FS, 1'b1, 16 + $urandom_range(7));
        rd(SEC, 32'h0);
        $display("test registers and key done");
        cmd(2'h1, 3'h5, 1'b1);
        op_end(1'b1);
        cmd(2'h1, 3'h4, 1'b0);
        rd(STA, st(1'b0, 6'h00));
        areset();
        rd(STA, st(1'b1, 6'h00));
        rd(SEC, 32'h0);
        key(FS, 1'b1, 0);
        rd(SEC, 32'h1);
        $display("test failure done");
        f = 6'h00;
        for (int m = 0; m < 4; m++)
        begin
            boot_mode <= m[1:0];
            repeat (3) @(posedge aclk);
            cmd(2'h1, m[2:0], m != 3);
            if (m != 3)
            begin
                rd(STA, st(1'b0, f));
                op_end(1'b0);
                f[m] = 1'b1;
                rd(STA, st(1'b1, f));
            end
        end
        boot_mode <= 2'h0;
        repeat (3) @(posedge aclk);
        cmd(2'h0, 3'h0, 1'b0);
        cmd(2'h0, 3'h4, 1'b1);
        op_end(1'b0);
        cmd(2'h1, 3'h6, 1'b0);
        cmd(2'h3, 3'h0, 1'b1);
        op_end(1'b0);
        cmd(2'h1, 3'h4, 1'b1);
        op_end(1'b0);
        cmd(2'h2, 3'h5, 1'b1);
        op_end(1'b0);
        rd(STA, st(1'b1, 6'h07));
        cmd(2'h2, 3'h1, 1'b1);
        op_end(1'b0);
        rd(STA, st(1'b1, 6'h00));
        $display("test protection done");
        for (int b = 0; b < 6; b++)
        begin
            cmd(2'h1, b[2:0], 1'b1);
            op_end(1'b0);
        end
        repeat (2) @(posedge aclk);
        check("lock", {flags, debug_block, trace_block}, 34'hff);
        cmd(2'h3, 3'h0, 1'b0);
        cmd(2'h2, 3'h4, 1'b1);
        op_end(1'b0);
        rd(STA, st(1'b1, 6'h00));
        check("unlock", {flags, debug_block, trace_block}, 34'h0);
        $display("test lock done");
        cmd(2'h1, 3'h0, 1'b1);
        cmd(2'h1, 3'h1, 1'b0);
        areset();
        repeat (RD - 2) @(posedge aclk);
        check("read_ready", {33'h0, read_ready}, 34'h0);
        repeat (4) @(posedge aclk);
        check("read_ready", {33'h0, read_ready}, 34'h1);
        rd(STA, st(1'b1, 6'h00));
        $display("test lockout done");
        conclude();
    end
endmodule
